// ### inc/tcc_consts.svh
// Constants of the 16-bit timer compare, capture and interrupt block.
// Assumes an 8-bit CPU byte bus and an external counter sequencer.
`ifndef TCC_CONSTS_SVH
`define TCC_CONSTS_SVH

// ----------------------------------------------------------------
// Byte addresses on the CPU bus
// ----------------------------------------------------------------
`define TCC_OFS_CNT_L    4'h0
`define TCC_OFS_CNT_H    4'h1
`define TCC_OFS_CAP_L    4'h2
`define TCC_OFS_CAP_H    4'h3
`define TCC_OFS_CMPA_L   4'h4
`define TCC_OFS_CMPA_H   4'h5
`define TCC_OFS_CMPB_L   4'h6
`define TCC_OFS_CMPB_H   4'h7
`define TCC_OFS_CMPC_L   4'h8
`define TCC_OFS_CMPC_H   4'h9
`define TCC_OFS_MASK     4'hA
`define TCC_OFS_FLAGS    4'hB

// ----------------------------------------------------------------
// Mask and flag bit positions, reset values
// ----------------------------------------------------------------
`define TCC_BIT_CAP      5
`define TCC_BIT_MC       3
`define TCC_BIT_MB       2
`define TCC_BIT_MA       1
`define TCC_BIT_OVF      0
`define TCC_FLAGS_RESET  5'h00
`define TCC_MASK_RESET   5'h00
`define TCC_WORD_RESET   16'h0000

// ----------------------------------------------------------------
// Waveform modes that matter here, and fixed tops
// ----------------------------------------------------------------
`define TCC_MODE_NORMAL  4'h0
`define TCC_MODE_CTC_A   4'h4
`define TCC_MODE_CTC_CAP 4'hC
`define TCC_TOP_8BIT     16'h00FF
`define TCC_TOP_9BIT     16'h01FF
`define TCC_TOP_10BIT    16'h03FF
`define TCC_TOP_MAX      16'hFFFF

`endif

// ### inc/tcc_pkg.sv
// Types of the timer compare, capture and interrupt block.
// Assumes nothing beyond a SystemVerilog compiler.
package tcc_pkg;

	typedef logic [3:0]  tcc_mode_t;
	typedef logic [15:0] tcc_word_t;

	// Flag vector order: overflow, match A, B, C, capture
	typedef logic [4:0]  tcc_irq_t;

	typedef struct packed
	{
		tcc_word_t value;
	} tcc_unit_state_t;

	typedef struct packed
	{
		logic [7:0] temp;
		tcc_word_t  capture;
		tcc_irq_t   flags;
		tcc_irq_t   mask;
		logic       src_prev;
		logic       load;
		tcc_word_t  load_value;
		logic       block;
		logic [7:0] rdata;
		logic [2:0] match_evt;
		logic [2:0] force_evt;
		logic       ctc_clear;
		tcc_word_t  top;
	} tcc_state_t;

endpackage

// ### inc/tcc_cmp_if.sv
// Link between the control logic and one compare unit.
// Assumes one instance per compare channel.
`timescale 1ns/1ps
interface tcc_cmp_if;
	logic [15:0] count;
	logic        wr_lo;
	logic [7:0]  wr_hi;
	logic [7:0]  wr_data;
	logic        block;
	logic [15:0] value;
	logic        match;

	modport unit
	(
		input  count,
		input  wr_lo,
		input  wr_hi,
		input  wr_data,
		input  block,
		output value,
		output match
	);

	modport ctrl
	(
		output count,
		output wr_lo,
		output wr_hi,
		output wr_data,
		output block,
		input  value,
		input  match
	);
endinterface

// ### hdl/tcc_cmp_unit.sv
// One 16-bit compare channel: value register and equality check.
// Assumes the controller supplies the high byte from the shared buffer.
`timescale 1ns/1ps
`include "tcc_consts.svh"
module tcc_cmp_unit
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// Control side
	tcc_cmp_if.unit  cmp
);
	import tcc_pkg::*;

	tcc_unit_state_t st_reg;
	tcc_unit_state_t st_next;

	always_comb
	begin
		st_next = st_reg;
		if (cmp.wr_lo)
			st_next.value = {cmp.wr_hi, cmp.wr_data};
	end

	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
			st_reg <= '{value: `TCC_WORD_RESET};
		else
			st_reg <= st_next;
	end

	assign cmp.value = st_reg.value;
	// Equality is checked every clock; blocked after a counter load
	assign cmp.match = (cmp.count == st_reg.value) && !cmp.block;
endmodule

// ### hdl/tcc_top.sv
// Compare, capture and interrupt bookkeeping of a 16-bit timer.
// Assumes an external counter sequencer that reports top, bottom and
// max events and loads the counter from count_load_value on count_load.
`timescale 1ns/1ps
`include "tcc_consts.svh"
module tcc_top
(
	// Clock and reset
	input  wire logic                sys_clk,
	input  wire logic                sys_rst,
	// CPU byte bus
	input  wire logic [3:0]          cpu_addr,
	input  wire logic                cpu_wr,
	input  wire logic                cpu_rd,
	input  wire logic [7:0]          cpu_wdata,
	output logic      [7:0]          cpu_rdata,
	// Counter sequencer
	input  wire tcc_pkg::tcc_word_t  count_value,
	input  wire logic                count_at_top,
	input  wire logic                count_at_bottom,
	input  wire logic                count_at_max,
	input  wire tcc_pkg::tcc_mode_t  waveform_mode_select,
	output logic                     count_load,
	output tcc_pkg::tcc_word_t       count_load_value,
	output tcc_pkg::tcc_word_t       top_value,
	output logic                     ctc_clear,
	// Capture source
	input  wire logic                capture_input_pin,
	input  wire logic                capture_edge_select,
	input  wire logic                comparator_out,
	input  wire logic                capture_from_comparator,
	// Compare events to waveform logic
	input  wire logic [2:0]          force_match_strobe,
	output logic      [2:0]          match_event,
	output logic      [2:0]          forced_event,
	// Interrupt requests
	input  wire logic                global_irq_enable,
	input  wire tcc_pkg::tcc_irq_t   irq_vector_ack,
	output tcc_pkg::tcc_irq_t        irq_request
);
	import tcc_pkg::*;

	// ----------------------------------------------------------------
	// Mode decoding
	// ----------------------------------------------------------------

	// Modes 8, 10, 12 and 14 take the capture register as top
	function automatic logic cap_is_top(input tcc_mode_t m);
		cap_is_top = m[3] && !m[0];
	endfunction

	// Modes 4, 9, 11 and 15 take compare A as top
	function automatic logic cmpa_is_top(input tcc_mode_t m);
		cmpa_is_top = (m == `TCC_MODE_CTC_A) || (m[3] && m[0] && m != 4'hD);
	endfunction

	// Force strobes only act outside the PWM modes
	function automatic logic is_non_pwm(input tcc_mode_t m);
		is_non_pwm = (m == `TCC_MODE_NORMAL) || (m == `TCC_MODE_CTC_A) ||
			(m == `TCC_MODE_CTC_CAP);
	endfunction

	function automatic tcc_word_t top_of(input tcc_mode_t m,
		input tcc_word_t cap, input tcc_word_t cmpa);
		tcc_word_t t;
		t = `TCC_TOP_MAX;
		if (cap_is_top(m))
			t = cap;
		else if (cmpa_is_top(m))
			t = cmpa;
		else
		begin
			case (m[1:0])
				2'h1: t = `TCC_TOP_8BIT;
				2'h2: t = `TCC_TOP_9BIT;
				2'h3: t = `TCC_TOP_10BIT;
				default: t = `TCC_TOP_MAX;
			endcase
		end
		top_of = t;
	endfunction

	// Overflow point per mode: max, bottom or top
	function automatic logic ovf_hit(input tcc_mode_t m, input logic at_top,
		input logic at_bottom, input logic at_max);
		logic r;
		r = 1'b0;
		case (m)
			4'h0, 4'h4, 4'hC, 4'hD: r = at_max;
			4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'hA, 4'hB: r = at_bottom;
			4'h5, 4'h6, 4'h7, 4'hE, 4'hF: r = at_top;
			default: r = 1'b0;
		endcase
		ovf_hit = r;
	endfunction

	// Byte layout of the mask and flag registers
	function automatic logic [7:0] irq_to_byte(input tcc_irq_t v);
		logic [7:0] b;
		b = 8'h00;
		b[`TCC_BIT_OVF] = v[0];
		b[`TCC_BIT_MA]  = v[1];
		b[`TCC_BIT_MB]  = v[2];
		b[`TCC_BIT_MC]  = v[3];
		b[`TCC_BIT_CAP] = v[4];
		irq_to_byte = b;
	endfunction

	function automatic tcc_irq_t byte_to_irq(input logic [7:0] b);
		byte_to_irq = {b[`TCC_BIT_CAP], b[`TCC_BIT_MC], b[`TCC_BIT_MB],
			b[`TCC_BIT_MA], b[`TCC_BIT_OVF]};
	endfunction

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	tcc_state_t       st_reg;
	tcc_state_t       st_next;
	logic [2:0][15:0] cmp_value;
	logic [2:0]       cmp_match;

	localparam logic [3:0] CMP_LO [3] =
		'{`TCC_OFS_CMPA_L, `TCC_OFS_CMPB_L, `TCC_OFS_CMPC_L};

	// ----------------------------------------------------------------
	// Compare channels
	// ----------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++)
		begin : g_cmp
			tcc_cmp_if cif ();
			assign cif.count   = count_value;
			assign cif.wr_lo   = cpu_wr && (cpu_addr == CMP_LO[gi]);
			assign cif.wr_hi   = st_reg.temp;
			assign cif.wr_data = cpu_wdata;
			assign cif.block   = st_reg.block;
			assign cmp_value[gi] = cif.value;
			assign cmp_match[gi] = cif.match;
			tcc_cmp_unit u_unit
			(
				.sys_clk (sys_clk),
				.sys_rst (sys_rst),
				.cmp     (cif)
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	logic     src;
	logic     cap_edge;
	logic     cap_top;
	tcc_irq_t set_v;
	tcc_irq_t clr_v;

	always_comb
	begin
		st_next = st_reg;
		cap_top = cap_is_top(waveform_mode_select);

		// Capture edge detect; the pin is ignored when capture is top
		src = capture_from_comparator ? comparator_out
			: capture_input_pin;
		cap_edge = !cap_top && (capture_edge_select ?
			(src && !st_reg.src_prev) :
			(!src && st_reg.src_prev));
		st_next.src_prev = src;

		// Counter load and the one-clock match block behind it
		st_next.load  = cpu_wr && (cpu_addr == `TCC_OFS_CNT_L);
		st_next.block = st_reg.load;
		if (cpu_wr && cpu_addr == `TCC_OFS_CNT_L)
			st_next.load_value = {st_reg.temp, cpu_wdata};

		// CPU writes
		clr_v = irq_vector_ack;
		if (cpu_wr)
		begin
			case (cpu_addr)
				`TCC_OFS_CNT_H, `TCC_OFS_CAP_H, `TCC_OFS_CMPA_H,
				`TCC_OFS_CMPB_H, `TCC_OFS_CMPC_H:
					st_next.temp = cpu_wdata;
				`TCC_OFS_CAP_L:
					st_next.capture = {st_reg.temp, cpu_wdata};
				`TCC_OFS_MASK:
					st_next.mask = byte_to_irq(cpu_wdata);
				`TCC_OFS_FLAGS:
					clr_v = clr_v | byte_to_irq(cpu_wdata);
				default:
					st_next.temp = st_reg.temp;
			endcase
		end

		// Hardware capture beats a same-cycle CPU write
		if (cap_edge)
			st_next.capture = count_value;

		// CPU reads; a counter or capture low read latches the matching high byte
		if (cpu_rd)
		begin
			case (cpu_addr)
				`TCC_OFS_CNT_L:
				begin
					st_next.rdata = count_value[7:0];
					st_next.temp  = count_value[15:8];
				end
				`TCC_OFS_CAP_L:
				begin
					st_next.rdata = st_reg.capture[7:0];
					st_next.temp  = st_reg.capture[15:8];
				end
				`TCC_OFS_CNT_H, `TCC_OFS_CAP_H:
					st_next.rdata = st_reg.temp;
				`TCC_OFS_CMPA_L: st_next.rdata = cmp_value[0][7:0];
				`TCC_OFS_CMPA_H: st_next.rdata = cmp_value[0][15:8];
				`TCC_OFS_CMPB_L: st_next.rdata = cmp_value[1][7:0];
				`TCC_OFS_CMPB_H: st_next.rdata = cmp_value[1][15:8];
				`TCC_OFS_CMPC_L: st_next.rdata = cmp_value[2][7:0];
				`TCC_OFS_CMPC_H: st_next.rdata = cmp_value[2][15:8];
				`TCC_OFS_MASK:   st_next.rdata = irq_to_byte(st_reg.mask);
				`TCC_OFS_FLAGS:  st_next.rdata = irq_to_byte(st_reg.flags);
				default:         st_next.rdata = 8'h00;
			endcase
		end

		// Flag sources; forced strobes are not among them
		set_v[0] = ovf_hit(waveform_mode_select, count_at_top,
			count_at_bottom, count_at_max);
		set_v[3:1] = cmp_match;
		set_v[4] = cap_top ? count_at_top : cap_edge;

		// Set wins over a clear in the same cycle
		st_next.flags = (st_reg.flags & ~clr_v) | set_v;

		// Events towards the waveform and counter logic
		st_next.match_evt = cmp_match;
		st_next.force_evt = is_non_pwm(waveform_mode_select) ?
			force_match_strobe : 3'h0;
		// Only real matches clear the counter, never a force
		st_next.ctc_clear =
			((waveform_mode_select == `TCC_MODE_CTC_A) && cmp_match[0]) ||
			((waveform_mode_select == `TCC_MODE_CTC_CAP) &&
			(count_value == st_reg.capture) && !st_reg.block);
		st_next.top = top_of(waveform_mode_select, st_reg.capture,
			cmp_value[0]);
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			st_reg            <= '0;
			st_reg.flags      <= `TCC_FLAGS_RESET;
			st_reg.mask       <= `TCC_MASK_RESET;
			st_reg.top        <= `TCC_TOP_MAX;
		end
		else
			st_reg <= st_next;
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign cpu_rdata        = st_reg.rdata;
	assign count_load       = st_reg.load;
	assign count_load_value = st_reg.load_value;
	assign top_value        = st_reg.top;
	assign ctc_clear        = st_reg.ctc_clear;
	assign match_event      = st_reg.match_evt;
	assign forced_event     = st_reg.force_evt;
	// Requests need mask, flag and the global enable together
	assign irq_request = st_reg.flags & st_reg.mask &
		{5{global_irq_enable}};
endmodule

// ### sim/tcc_top_chk.sv
// Port checker for the timer compare, capture and interrupt block.
// Assumes a bind to tcc_top and sees only its ports.
`timescale 1ns/1ps
`include "tcc_consts.svh"
module tcc_top_chk
(
	// Clock and reset
	input wire logic               sys_clk,
	input wire logic               sys_rst,
	// CPU bus
	input wire logic [3:0]         cpu_addr,
	input wire logic               cpu_wr,
	input wire logic               cpu_rd,
	input wire logic [7:0]         cpu_wdata,
	input wire logic [7:0]         cpu_rdata,
	// Timer side
	input wire tcc_pkg::tcc_mode_t waveform_mode_select,
	input wire logic [2:0]         force_match_strobe,
	input wire logic               global_irq_enable,
	input wire logic               count_load,
	input wire tcc_pkg::tcc_word_t count_load_value,
	input wire tcc_pkg::tcc_word_t top_value,
	input wire logic               ctc_clear,
	input wire logic [2:0]         match_event,
	input wire logic [2:0]         forced_event,
	input wire tcc_pkg::tcc_irq_t  irq_request
);
	import tcc_pkg::*;
	// ----------------
	// Port relations
	// ----------------
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (sys_rst);

	a_irq_global: assert property (!global_irq_enable |-> !irq_request)
		else $error("request while globally disabled");
	a_match_b_irq: assert property ($rose(irq_request[2]) &&
		$past(global_irq_enable) && !$past(cpu_wr) |-> match_event[1])
		else $error("match B request without a match");
	a_rdata_hold: assert property (!cpu_rd |=> $stable(cpu_rdata))
		else $error("read data moved without a read");
	a_load_start: assert property (cpu_wr && cpu_addr == `TCC_OFS_CNT_L
		|=> count_load && count_load_value[7:0] == $past(cpu_wdata))
		else $error("counter low write did not load");
	a_load_cause: assert property (count_load |->
		$past(cpu_wr) && $past(cpu_addr) == `TCC_OFS_CNT_L)
		else $error("load without counter write");
	a_match_block: assert property (count_load |-> ##2 !match_event)
		else $error("match right after counter write");
	a_force_mode: assert property (forced_event != 3'h0 |->
		$past(waveform_mode_select) inside {`TCC_MODE_NORMAL,
		`TCC_MODE_CTC_A, `TCC_MODE_CTC_CAP} &&
		$past(force_match_strobe) == forced_event)
		else $error("forced event outside non-pwm mode");
	a_ctc_mode: assert property (ctc_clear |->
		$past(waveform_mode_select) inside {`TCC_MODE_CTC_A, `TCC_MODE_CTC_CAP})
		else $error("clear outside ctc modes");
	a_top_fixed: assert property (!$past(sys_rst) &&
		$past(waveform_mode_select) == 4'h1 |-> top_value == `TCC_TOP_8BIT)
		else $error("top wrong in 8-bit mode");
endmodule

bind tcc_top tcc_top_chk i_tcc_top_chk (.sys_clk, .sys_rst, .cpu_addr,
	.cpu_wr, .cpu_rd, .cpu_wdata, .cpu_rdata, .waveform_mode_select,
	.force_match_strobe, .global_irq_enable, .count_load, .count_load_value,
	.top_value, .ctc_clear, .match_event, .forced_event, .irq_request);

// ### sim/tb.sv
// Self-checking bench of the timer compare, capture and interrupt block.
// Assumes the bench plays CPU and counter sequencer; inputs at falling edge.
`timescale 1ns/1ps
`include "tcc_consts.svh"
module tb;
	import tcc_pkg::*;
	logic       sys_clk, sys_rst, cpu_wr, cpu_rd, count_at_top;
	logic       count_at_bottom, count_at_max, capture_input_pin;
	logic       capture_edge_select, comparator_out, capture_from_comparator;
	logic       global_irq_enable, count_load, ctc_clear;
	logic [3:0] cpu_addr;
	logic [7:0] cpu_wdata, cpu_rdata, rb;
	logic [2:0] force_match_strobe, match_event, forced_event;
	tcc_word_t  count_value, count_load_value, top_value;
	tcc_mode_t  waveform_mode_select;
	tcc_irq_t   irq_vector_ack, irq_request;
	tcc_mode_t  ovf_mode [3] = '{4'h0, 4'h1, 4'h5};
	int         mismatches = 0;
	int         check_count = 0;
	int         cycles = 0;

	tcc_top i_tcc_top (.sys_clk, .sys_rst, .cpu_addr, .cpu_wr, .cpu_rd,
		.cpu_wdata, .cpu_rdata, .count_value, .count_at_top, .count_at_bottom,
		.count_at_max, .waveform_mode_select, .count_load, .count_load_value,
		.top_value, .ctc_clear, .capture_input_pin, .capture_edge_select,
		.comparator_out, .capture_from_comparator, .force_match_strobe,
		.match_event, .forced_event, .global_irq_enable, .irq_vector_ack,
		.irq_request);

	// ----------------
	// Bus tasks, entered at a falling edge
	// ----------------
	task automatic step(int n = 1);
		repeat (n) @(negedge sys_clk);
	endtask
	task automatic chk(string s, tcc_word_t e, tcc_word_t g);
		check_count++;
		if (g !== e)
		begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", s, e, g);
		end
	endtask
	// A free cycle follows each strobe so it is never re-raised in one step
	task automatic wr8(logic [3:0] a, logic [7:0] d);
		cpu_wr = 1'b1;
		cpu_addr = a;
		cpu_wdata = d;
		step();
		cpu_wr = 1'b0;
		step();
	endtask
	task automatic wr16(logic [3:0] a, tcc_word_t v);
		wr8(a + 4'h1, v[15:8]);
		wr8(a, v[7:0]);
	endtask
	task automatic rd8(logic [3:0] a);
		cpu_rd = 1'b1;
		cpu_addr = a;
		step();
		cpu_rd = 1'b0;
		rb = cpu_rdata;
		step();
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	initial
	begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			mismatches++;
			final_report();
		end
	end

	// ----------------
	// Main sequence
	// ----------------
	initial
	begin
		{sys_rst, cpu_wr, cpu_rd, count_at_top, count_at_bottom} = 5'h10;
		{count_at_max, capture_input_pin, capture_edge_select} = 3'h0;
		{comparator_out, capture_from_comparator, global_irq_enable} = 3'h0;
		{cpu_addr, cpu_wdata, force_match_strobe, irq_vector_ack} = 20'h00000;
		count_value = 16'h5555;
		waveform_mode_select = `TCC_MODE_NORMAL;
		step(12);
		sys_rst = 1'b0;
		rd8(`TCC_OFS_MASK);
		chk("mask", 16'h0000, rb);
		rd8(`TCC_OFS_FLAGS);
		chk("flags", 16'h0000, rb);
		chk("top", `TCC_TOP_MAX, top_value);
		wr16(`TCC_OFS_CMPA_L, 16'h1234);
		rd8(`TCC_OFS_CMPA_H);
		chk("cmpa hi", 16'h0012, rb);
		// Capture low read replaces the buffered compare high byte
		wr8(`TCC_OFS_CMPB_H, 8'hAB);
		rd8(`TCC_OFS_CAP_L);
		wr8(`TCC_OFS_CMPB_L, 8'hCD);
		rd8(`TCC_OFS_CMPB_H);
		chk("temp share", 16'h0000, rb);
		wr8(`TCC_OFS_MASK, 8'h2F);
		global_irq_enable = 1'b1;
		for (int i = 0; i < 3; i++)
		begin
			wr16(4'(`TCC_OFS_CMPA_L + 2 * i), 16'(16'h0100 + i));
			count_value = 16'(16'h0100 + i);
			step();
			count_value = 16'h5555;
			chk("match", 16'(1 << i), match_event);
			chk("irq", 16'(2 << i), irq_request);
			wr8(`TCC_OFS_FLAGS, 8'(2 << i));
			chk("irq clr", 16'h0000, irq_request);
		end
		wr16(`TCC_OFS_CNT_L, 16'h0100);
		chk("load", 16'h0100, count_load_value);
		count_value = 16'h0100;
		step();
		chk("blocked", 16'h0000, match_event);
		step();
		chk("unblocked", 16'h0001, match_event);
		count_value = 16'h5555;
		global_irq_enable = 1'b0;
		#1;
		chk("irq off", 16'h0000, irq_request);
		global_irq_enable = 1'b1;
		wr8(`TCC_OFS_FLAGS, 8'h00);
		rd8(`TCC_OFS_FLAGS);
		chk("zero wr", 16'h0002, rb);
		irq_vector_ack = 5'h02;
		step();
		irq_vector_ack = 5'h00;
		waveform_mode_select = `TCC_MODE_CTC_A;
		force_match_strobe = 3'h7;
		step();
		force_match_strobe = 3'h0;
		chk("forced", 16'h0007, forced_event);
		chk("no clear", 16'h0000, ctc_clear);
		waveform_mode_select = 4'h5;
		force_match_strobe = 3'h7;
		step();
		force_match_strobe = 3'h0;
		chk("pwm force", 16'h0000, forced_event);
		rd8(`TCC_OFS_FLAGS);
		chk("ack flags", 16'h0000, rb);
		wr8(`TCC_OFS_MASK, 8'h01);
		for (int j = 0; j < 3; j++)
			for (int k = 0; k < 3; k++)
			begin
				waveform_mode_select = ovf_mode[j];
				{count_at_top, count_at_bottom, count_at_max} = 3'(1 << k);
				step();
				{count_at_top, count_at_bottom, count_at_max} = 3'h0;
				chk("ovf irq", 16'(j == k), irq_request);
				irq_vector_ack = 5'h01;
				step();
				irq_vector_ack = 5'h00;
				chk("ovf ack", 16'h0000, irq_request);
			end
		waveform_mode_select = `TCC_MODE_NORMAL;
		wr8(`TCC_OFS_MASK, 8'h20);
		capture_edge_select = 1'b1;
		count_value = 16'h4321;
		capture_input_pin = 1'b1;
		step();
		chk("cap irq", 16'h0010, irq_request);
		rd8(`TCC_OFS_CAP_L);
		chk("cap lo", 16'h0021, rb);
		count_value = 16'h8765;
		capture_input_pin = 1'b0;
		step();
		capture_input_pin = 1'b1;
		step();
		count_value = 16'h9999;
		capture_input_pin = 1'b0;
		step();
		rd8(`TCC_OFS_CAP_H);
		chk("cap coherent", 16'h0043, rb);
		rd8(`TCC_OFS_CAP_L);
		chk("cap edge", 16'h0065, rb);
		capture_edge_select = 1'b0;
		capture_from_comparator = 1'b1;
		comparator_out = 1'b1;
		step();
		count_value = 16'h2222;
		comparator_out = 1'b0;
		step();
		count_value = 16'h5555;
		rd8(`TCC_OFS_CAP_L);
		chk("cmp src", 16'h0022, rb);
		capture_from_comparator = 1'b0;
		wr8(`TCC_OFS_FLAGS, 8'h00);
		chk("zero wr", 16'h0010, irq_request);
		wr8(`TCC_OFS_FLAGS, 8'h20);
		chk("one wr", 16'h0000, irq_request);
		waveform_mode_select = `TCC_MODE_CTC_CAP;
		wr16(`TCC_OFS_CAP_L, 16'h0ABC);
		capture_edge_select = 1'b1;
		capture_input_pin = 1'b1;
		step();
		chk("pin off", 16'h0000, irq_request);
		chk("cap top", 16'h0ABC, top_value);
		count_at_top = 1'b1;
		step();
		count_at_top = 1'b0;
		chk("top flag", 16'h0010, irq_request);
		irq_vector_ack = 5'h10;
		step();
		irq_vector_ack = 5'h00;
		chk("cap ack", 16'h0000, irq_request);
		count_value = 16'h0ABC;
		step();
		count_value = 16'h5555;
		chk("ctc", 16'h0001, ctc_clear);
		waveform_mode_select = `TCC_MODE_CTC_A;
		count_value = 16'h0100;
		step();
		count_value = 16'h5555;
		chk("ctc a", 16'h0001, ctc_clear);
		final_report();
	end
endmodule
